// ==== design/mcp_top.sv ====
// top of the 16-bit math coprocessor with its five byte-addressed registers
// assumes a host on the same clock driving a byte-wide peripheral bus
`timescale 1ns/1ps
`include "mcp_regs.svh"

module mcp_top (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_BUSY
);
  logic [31:0] prod_reg;
  logic [15:0] opa_reg;
  logic [15:0] opb_reg;
  logic [3:0] ctrl_reg;
  logic minus_reg;
  logic remz_reg;
  logic ovfl_reg;
  logic zdiv_reg;
  logic done_reg;
  logic busy_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;
  logic op_signed_reg;
  logic op_comp_reg;
  mcp_pkg::mcp_state_t state_reg;
  mcp_pkg::mcp_state_t state_next;
  mcp_pkg::mcp_op_t op_reg;
  mcp_pkg::mcp_op_t op_next;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_opa_lo;
  logic wr_opb_lo;
  logic kick;
  logic trig;
  logic [3:0] mode_now;
  logic is_div;
  logic opa_zero;
  logic mul_fin;
  logic zdiv_fin;
  logic div_fin;
  logic div_start;
  logic [31:0] mul_result;
  logic mul_ovfl;
  logic [31:0] div_num;
  logic [31:0] div_quot;
  logic [15:0] div_rem;
  logic div_ovfl;
  logic div_done;
  logic [31:0] frac_mag;
  logic ovfl_set;

  // ************************************************************
  // bus decode and start triggers
  // ************************************************************
  // byte strobes at the printed addresses
  assign wr_ctrl = I_WR && (I_ADDR == `MCP_ADDR_CTRL);
  assign wr_flags = I_WR && (I_ADDR == `MCP_ADDR_FLAGS);
  assign wr_opa_lo = I_WR && (I_ADDR == `MCP_ADDR_OPA_LO);
  assign wr_opb_lo = I_WR && (I_ADDR == `MCP_ADDR_OPB_LO);
  // a control write with the kick bit uses the mode it writes
  assign kick = wr_ctrl && I_WDATA[`MCP_CTL_KICK_BIT];
  assign mode_now = wr_ctrl ? I_WDATA[`MCP_CTL_SIGNED_BIT:`MCP_CTL_COMP_BIT] : ctrl_reg;
  assign trig = (state_reg == mcp_pkg::MCP_ST_IDLE) && (kick
    || (!mode_now[2] && wr_opb_lo)
    || (mode_now[2] && !mode_now[1] && wr_opa_lo));

  // function from the quotient and accumulate selects
  always_comb begin
    case ({mode_now[2], mode_now[1]})
      2'b00: op_next = mcp_pkg::MCP_OP_MUL;
      2'b01: op_next = mcp_pkg::MCP_OP_MULACC;
      2'b10: op_next = mcp_pkg::MCP_OP_INTQ;
      default: op_next = mcp_pkg::MCP_OP_FRACQ;
    endcase
  end

  // ************************************************************
  // sequencing
  // ************************************************************
  assign is_div = (op_reg == mcp_pkg::MCP_OP_INTQ) || (op_reg == mcp_pkg::MCP_OP_FRACQ);
  assign opa_zero = (opa_reg == 16'h0000);
  assign mul_fin = (state_reg == mcp_pkg::MCP_ST_GO) && !is_div;
  assign zdiv_fin = (state_reg == mcp_pkg::MCP_ST_GO) && is_div && opa_zero;
  assign div_start = (state_reg == mcp_pkg::MCP_ST_GO) && is_div && !opa_zero;
  assign div_fin = (state_reg == mcp_pkg::MCP_ST_DIV) && div_done;

  // next state: go one cycle after the trigger so new operands are seen
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcp_pkg::MCP_ST_IDLE: begin
        if (trig) begin
          state_next = mcp_pkg::MCP_ST_GO;
        end
      end
      mcp_pkg::MCP_ST_GO: begin
        if (div_start) begin
          state_next = mcp_pkg::MCP_ST_DIV;
        end else begin
          state_next = mcp_pkg::MCP_ST_IDLE;
        end
      end
      mcp_pkg::MCP_ST_DIV: begin
        if (div_done) begin
          state_next = mcp_pkg::MCP_ST_IDLE;
        end
      end
      default: state_next = mcp_pkg::MCP_ST_IDLE;
    endcase
  end

  // state, busy and the latched function
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= mcp_pkg::MCP_ST_IDLE;
      busy_reg <= 1'b0;
      op_reg <= mcp_pkg::MCP_OP_MUL;
      op_signed_reg <= 1'b0;
      op_comp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != mcp_pkg::MCP_ST_IDLE);
      if (trig) begin
        op_reg <= op_next;
        op_signed_reg <= mode_now[3];
        op_comp_reg <= mode_now[3] & mode_now[0];
      end
    end
  end

  // ************************************************************
  // arithmetic units
  // ************************************************************
  mcp_mul u_mul (
    .i_signed(op_signed_reg),
    .i_acc(op_reg == mcp_pkg::MCP_OP_MULACC),
    .i_opa(opa_reg),
    .i_opb(opb_reg),
    .i_prod(prod_reg),
    .o_result(mul_result),
    .o_ovfl(mul_ovfl)
  );

  // fraction divide continues from the remainder left in operand b
  assign div_num = (op_reg == mcp_pkg::MCP_OP_FRACQ) ? {opb_reg, 16'h0000} : prod_reg;

  mcp_div u_div (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_start(div_start),
    .i_signed(op_signed_reg),
    .i_comp(op_comp_reg),
    .i_num(div_num),
    .i_den(opa_reg),
    .o_done(div_done),
    .o_quot(div_quot),
    .o_rem(div_rem),
    .o_ovfl(div_ovfl)
  );

  // fraction carries no sign bit, only its magnitude
  assign frac_mag = div_quot[31] ? (32'h00000000 - div_quot) : div_quot;

  // ************************************************************
  // data registers
  // ************************************************************
  // no reset: contents undefined until written or computed
  always_ff @(posedge I_CLK) begin
    if (mul_fin) begin
      prod_reg <= mul_result;
    end else if (div_fin) begin
      if (op_reg == mcp_pkg::MCP_OP_FRACQ) begin
        prod_reg <= {prod_reg[15:0], frac_mag[15:0]};
      end else begin
        prod_reg <= div_quot;
      end
      opb_reg <= div_rem;
    end else if (I_WR && (state_reg == mcp_pkg::MCP_ST_IDLE)) begin
      case (I_ADDR)
        `MCP_ADDR_PROD3: prod_reg[31:24] <= I_WDATA;
        `MCP_ADDR_PROD2: prod_reg[23:16] <= I_WDATA;
        `MCP_ADDR_PROD1: prod_reg[15:8] <= I_WDATA;
        `MCP_ADDR_PROD0: prod_reg[7:0] <= I_WDATA;
        `MCP_ADDR_OPA_HI: opa_reg[15:8] <= I_WDATA;
        `MCP_ADDR_OPA_LO: opa_reg[7:0] <= I_WDATA;
        `MCP_ADDR_OPB_HI: opb_reg[15:8] <= I_WDATA;
        `MCP_ADDR_OPB_LO: opb_reg[7:0] <= I_WDATA;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // control and flags
  // ************************************************************
  // mode bits stored, kick never stored
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_reg <= `MCP_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= I_WDATA[`MCP_CTL_SIGNED_BIT:`MCP_CTL_COMP_BIT];
    end
  end

  assign ovfl_set = (mul_fin && mul_ovfl)
    || (div_fin && (div_ovfl || ((op_reg == mcp_pkg::MCP_OP_FRACQ) && (frac_mag[31:16] != 16'h0000))));

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      minus_reg <= 1'b0;
      remz_reg <= 1'b0;
      ovfl_reg <= 1'b0;
      zdiv_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (mul_fin) begin
        minus_reg <= op_signed_reg & mul_result[31];
        remz_reg <= 1'b0;
      end else if (div_fin) begin
        minus_reg <= op_signed_reg & div_quot[31];
        remz_reg <= (div_rem == 16'h0000);
      end else if (zdiv_fin) begin
        remz_reg <= 1'b0;
      end
      ovfl_reg <= ovfl_set || (ovfl_reg && !(wr_flags && I_WDATA[`MCP_FLG_OVFL_BIT]));
      zdiv_reg <= zdiv_fin || (zdiv_reg && !(wr_flags && I_WDATA[`MCP_FLG_ZDIV_BIT]));
      done_reg <= mul_fin || zdiv_fin || div_fin || (done_reg && !(wr_flags && I_WDATA[`MCP_FLG_DONE_BIT]));
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // unmapped and unimplemented bits read zero
  always_comb begin
    rd_mux = 8'h00;
    case (I_ADDR)
      `MCP_ADDR_PROD3: rd_mux = prod_reg[31:24];
      `MCP_ADDR_PROD2: rd_mux = prod_reg[23:16];
      `MCP_ADDR_PROD1: rd_mux = prod_reg[15:8];
      `MCP_ADDR_PROD0: rd_mux = prod_reg[7:0];
      `MCP_ADDR_CTRL: rd_mux = {ctrl_reg, 4'h0};
      `MCP_ADDR_OPA_HI: rd_mux = opa_reg[15:8];
      `MCP_ADDR_OPA_LO: rd_mux = opa_reg[7:0];
      `MCP_ADDR_OPB_HI: rd_mux = opb_reg[15:8];
      `MCP_ADDR_OPB_LO: rd_mux = opb_reg[7:0];
      `MCP_ADDR_FLAGS: rd_mux = {minus_reg, remz_reg, 3'b000, ovfl_reg, zdiv_reg, done_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data lands one cycle after the strobe and holds
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_reg <= 8'h00;
    end else if (I_RD) begin
      rdata_reg <= rd_mux;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_BUSY = busy_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  chk_kick_reads_zero: assert property ($past(I_RD) && ($past(I_ADDR) == `MCP_ADDR_CTRL) |-> O_RDATA[3:0] == 4'h0)
    else $error("control low nibble not zero");
  chk_mul_done_two: assert property ((state_reg == mcp_pkg::MCP_ST_IDLE) && wr_opb_lo && !wr_ctrl && !ctrl_reg[2]
    |=> O_BUSY ##1 (done_reg && !O_BUSY && prod_reg == $past(mul_result)))
    else $error("multiply did not finish in two cycles");
  chk_fracq_kick_only: assert property ((state_reg == mcp_pkg::MCP_ST_IDLE) && !kick && ctrl_reg[2] && ctrl_reg[1]
    |=> state_reg == mcp_pkg::MCP_ST_IDLE)
    else $error("fraction divide started without kick");
  chk_intq_latency: assert property ((state_reg == mcp_pkg::MCP_ST_IDLE) && wr_opa_lo && !wr_ctrl
    && ctrl_reg[2] && !ctrl_reg[1] && (I_WDATA != 8'h00) |=> O_BUSY [*8] ##[1:40] (done_reg && !O_BUSY))
    else $error("integer divide not finished in bound");
  chk_zdiv_flag: assert property (zdiv_fin |=> zdiv_reg && done_reg && !O_BUSY)
    else $error("divide by zero not flagged");
  chk_ovfl_clear: assert property (wr_flags && I_WDATA[`MCP_FLG_OVFL_BIT] && !ovfl_set |=> !ovfl_reg)
    else $error("overflow flag not cleared");
  chk_minus_readonly: assert property (wr_flags && !mul_fin && !div_fin |=> $stable(minus_reg))
    else $error("minus flag changed by write");
  chk_busy_holds_opa: assert property (O_BUSY && I_WR && !div_fin |=> $stable(opa_reg))
    else $error("operand a changed while busy");
  chk_remz_match: assert property (div_fin |=> remz_reg == (opb_reg == 16'h0000))
    else $error("remainder zero flag mismatch");
  chk_done_set_wins: assert property ((mul_fin || div_fin) && wr_flags |=> done_reg)
    else $error("done flag lost on clear");
endmodule

// ==== design/mcp_regs.svh ====
// register map, field positions and reset values of the math coprocessor
// assumes a byte-wide peripheral bus with byte addresses
`ifndef MCP_REGS_SVH
`define MCP_REGS_SVH

// ************************************************************
// byte addresses in the peripheral space
// ************************************************************
`define MCP_ADDR_PROD3 8'h40
`define MCP_ADDR_PROD2 8'h41
`define MCP_ADDR_PROD1 8'h42
`define MCP_ADDR_PROD0 8'h43
`define MCP_ADDR_CTRL 8'h44
`define MCP_ADDR_OPA_HI 8'h45
`define MCP_ADDR_OPA_LO 8'h46
`define MCP_ADDR_OPB_HI 8'h47
`define MCP_ADDR_OPB_LO 8'h48
`define MCP_ADDR_FLAGS 8'h49

// ************************************************************
// arith_control_reg fields
// ************************************************************
`define MCP_CTL_SIGNED_BIT 7
`define MCP_CTL_QUOT_BIT 6
`define MCP_CTL_ACC_BIT 5
`define MCP_CTL_COMP_BIT 4
`define MCP_CTL_KICK_BIT 3
`define MCP_CTL_RESET 4'h0

// ************************************************************
// arith_flags_reg fields
// ************************************************************
`define MCP_FLG_MINUS_BIT 7
`define MCP_FLG_REMZ_BIT 6
`define MCP_FLG_OVFL_BIT 2
`define MCP_FLG_ZDIV_BIT 1
`define MCP_FLG_DONE_BIT 0

// ************************************************************
// timing
// ************************************************************
`define MCP_DIV_LAST_STEP 5'd31

`endif

// ==== design/mcp_pkg.sv ====
// types shared by the coprocessor modules
// assumes nothing of its surroundings
package mcp_pkg;

  // controller states
  typedef enum logic [2:0] {
    MCP_ST_IDLE = 3'b001,
    MCP_ST_GO = 3'b010,
    MCP_ST_DIV = 3'b100
  } mcp_state_t;

  // latched function
  typedef enum logic [3:0] {
    MCP_OP_MUL = 4'b0001,
    MCP_OP_MULACC = 4'b0010,
    MCP_OP_INTQ = 4'b0100,
    MCP_OP_FRACQ = 4'b1000
  } mcp_op_t;

  // divider states
  typedef enum logic [2:0] {
    MCP_DS_IDLE = 3'b001,
    MCP_DS_RUN = 3'b010,
    MCP_DS_DONE = 3'b100
  } mcp_dstate_t;

endpackage

// ==== design/mcp_mul.sv ====
// single-cycle 16x16 multiplier with optional 32-bit accumulate
// assumes registered operands from the coprocessor top
`timescale 1ns/1ps
module mcp_mul (
  input wire logic i_signed,
  input wire logic i_acc,
  input wire logic [15:0] i_opa,
  input wire logic [15:0] i_opb,
  input wire logic [31:0] i_prod,
  output logic [31:0] o_result,
  output logic o_ovfl
);
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] full;
  logic [31:0] addend;
  logic [32:0] sum;

  // ************************************************************
  // product and accumulate
  // ************************************************************
  // sign or zero extension picks the number kind
  assign a_ext = {i_signed & i_opa[15], i_opa};
  assign b_ext = {i_signed & i_opb[15], i_opb};
  assign full = a_ext * b_ext;
  assign addend = i_acc ? i_prod : 32'h00000000;
  assign sum = {1'b0, full[31:0]} + {1'b0, addend};
  assign o_result = sum[31:0];
  // carry out of bit 31, or two's complement overflow when signed
  assign o_ovfl = i_acc & (i_signed ? ((full[31] == i_prod[31]) && (sum[31] != full[31])) : sum[32]);
endmodule

// ==== design/mcp_div.sv ====
// sequential 32 by 16 restoring divider with sign fix and floor compensation
// assumes a one-cycle start pulse and stable controls while running
`timescale 1ns/1ps
`include "mcp_regs.svh"
module mcp_div (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_signed,
  input wire logic i_comp,
  input wire logic [31:0] i_num,
  input wire logic [15:0] i_den,
  output logic o_done,
  output logic [31:0] o_quot,
  output logic [15:0] o_rem,
  output logic o_ovfl
);
  mcp_pkg::mcp_dstate_t st_reg;
  logic [4:0] cnt_reg;
  logic [31:0] work_reg;
  logic [31:0] mag_num_reg;
  logic [15:0] rem_reg;
  logic [15:0] den_reg;
  logic num_minus_reg;
  logic den_minus_reg;
  logic comp_reg;
  logic signed_reg;
  logic [16:0] shifted;
  logic [16:0] trial;
  logic fits;
  logic q_minus;
  logic adjust;
  logic [31:0] q_trunc;
  logic [15:0] r_trunc;
  logic [15:0] den_orig;

  // ************************************************************
  // one restoring step
  // ************************************************************
  assign shifted = {rem_reg, work_reg[31]};
  assign trial = shifted - {1'b0, den_reg};
  assign fits = (shifted >= {1'b0, den_reg});

  // start latches magnitudes, then 32 steps, then one done cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= mcp_pkg::MCP_DS_IDLE;
      cnt_reg <= 5'd0;
      work_reg <= 32'h00000000;
      mag_num_reg <= 32'h00000000;
      rem_reg <= 16'h0000;
      den_reg <= 16'h0000;
      num_minus_reg <= 1'b0;
      den_minus_reg <= 1'b0;
      comp_reg <= 1'b0;
      signed_reg <= 1'b0;
    end else begin
      case (st_reg)
        mcp_pkg::MCP_DS_IDLE: begin
          if (i_start) begin
            num_minus_reg <= i_signed & i_num[31];
            den_minus_reg <= i_signed & i_den[15];
            work_reg <= (i_signed & i_num[31]) ? (32'h00000000 - i_num) : i_num;
            mag_num_reg <= (i_signed & i_num[31]) ? (32'h00000000 - i_num) : i_num;
            den_reg <= (i_signed & i_den[15]) ? (16'h0000 - i_den) : i_den;
            rem_reg <= 16'h0000;
            cnt_reg <= 5'd0;
            comp_reg <= i_comp;
            signed_reg <= i_signed;
            st_reg <= mcp_pkg::MCP_DS_RUN;
          end
        end
        mcp_pkg::MCP_DS_RUN: begin
          work_reg <= {work_reg[30:0], fits};
          rem_reg <= fits ? trial[15:0] : shifted[15:0];
          cnt_reg <= cnt_reg + 5'd1;
          if (cnt_reg == `MCP_DIV_LAST_STEP) begin
            st_reg <= mcp_pkg::MCP_DS_DONE;
          end
        end
        mcp_pkg::MCP_DS_DONE: begin
          st_reg <= mcp_pkg::MCP_DS_IDLE;
        end
        default: begin
          st_reg <= mcp_pkg::MCP_DS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // sign fix and compensation
  // ************************************************************
  // truncating result, optionally floored so quotient chains stay consistent
  assign q_minus = num_minus_reg ^ den_minus_reg;
  assign q_trunc = q_minus ? (32'h00000000 - work_reg) : work_reg;
  assign r_trunc = num_minus_reg ? (16'h0000 - rem_reg) : rem_reg;
  assign den_orig = den_minus_reg ? (16'h0000 - den_reg) : den_reg;
  assign adjust = comp_reg & q_minus & (rem_reg != 16'h0000);
  assign o_quot = adjust ? (q_trunc - 32'h00000001) : q_trunc;
  assign o_rem = adjust ? (r_trunc + den_orig) : r_trunc;
  assign o_ovfl = signed_reg & ~q_minus & work_reg[31];
  assign o_done = (st_reg == mcp_pkg::MCP_DS_DONE);

  // ************************************************************
  // checks
  // ************************************************************
  chk_div_latency_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_start && st_reg == mcp_pkg::MCP_DS_IDLE) |-> ##33 o_done)
    else $error("divider did not finish in 33 cycles");
  chk_div_magnitude_exact: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_done |-> (({16'h0000, work_reg} * {32'h00000000, den_reg}) + {32'h00000000, rem_reg}
      == {16'h0000, mag_num_reg}) && (rem_reg < den_reg))
    else $error("divider magnitudes inconsistent");
endmodule

// ==== testbench/mcp_host.sv ====
// host cpu model: byte-wide register bus master of the coprocessor
// assumes the device samples strobes on the rising clock edge
`timescale 1ns/1ps
module mcp_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // ************************************************************
  // bus idle at time zero
  // ************************************************************
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // one write cycle, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask

  // one read cycle, byte taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// ==== testbench/math_coprocessor_16bit_tb.sv ====
// self-checking bench of the coprocessor top
// assumes the host model drives the bus at falling edges
`timescale 1ns/1ps
module math_coprocessor_16bit_tb;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic busy;
  logic [7:0] b8;
  int num_errors;
  int samples_checked;

  // ************************************************************
  // clock and instances
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  mcp_top dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_BUSY(busy));
  mcp_host host_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // high byte first, low byte write is the trigger
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    host_u.wr(a, v[15:8]);
    host_u.wr(a + 8'h01, v[7:0]);
  endtask

  task automatic wr_prod(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h40 + 8'(i), v[31 - 8 * i -: 8]);
    end
  endtask

  // wait for done, compare product, operand b, flags, then clear sticky flags
  task automatic res(input logic [31:0] ep, input logic [15:0] eb, input logic [7:0] ef);
    logic [31:0] p;
    int n;
    n = 0;
    b8 = 8'h00;
    while (b8[0] !== 1'b1) begin
      host_u.rd(8'h49, b8);
      n++;
      if (n > 60) begin
        num_errors++;
        complete_run();
      end
    end
    for (int i = 0; i < 4; i++) begin
      host_u.rd(8'h40 + 8'(i), b8);
      p[31 - 8 * i -: 8] = b8;
    end
    chk(p, ep);
    host_u.rd(8'h47, b8);
    p[15:8] = b8;
    host_u.rd(8'h48, b8);
    chk({16'h0, p[15:8], b8}, {16'h0, eb});
    host_u.rd(8'h49, b8);
    chk({24'h0, b8}, {24'h0, ef});
    host_u.wr(8'h49, 8'h07);
    host_u.rd(8'h49, b8);
    chk({29'h0, b8[2:0]}, 32'h0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    host_u.rd(8'h44, b8);
    chk({24'h0, b8}, 32'h0);
    host_u.rd(8'h49, b8);
    chk({24'h0, b8}, 32'h0);
    host_u.rd(8'h4a, b8);
    chk({24'h0, b8}, 32'h0);
    // unsigned multiply started by operand b
    wr16(8'h45, 16'hffff);
    wr16(8'h47, 16'hffff);
    res(32'hfffe0001, 16'hffff, 8'h01);
    // signed multiply, minus flag not writable
    host_u.wr(8'h44, 8'h80);
    wr16(8'h45, 16'hfffd);
    wr16(8'h47, 16'h0005);
    res(32'hfffffff1, 16'h0005, 8'h81);
    host_u.wr(8'h49, 8'h00);
    host_u.rd(8'h49, b8);
    chk({24'h0, b8}, 32'h80);
    // unsigned accumulate with carry out
    host_u.wr(8'h44, 8'h20);
    wr16(8'h45, 16'h0001);
    wr16(8'h47, 16'h0010);
    res(32'h00000001, 16'h0010, 8'h05);
    // unsigned integer divide started by operand a
    host_u.wr(8'h44, 8'h40);
    wr_prod(32'h00000064);
    wr16(8'h45, 16'h0007);
    @(negedge clk);
    chk({31'h0, busy}, 32'h1);
    // operand write while busy must be refused
    host_u.wr(8'h46, 8'h09);
    res(32'h0000000e, 16'h0002, 8'h01);
    host_u.rd(8'h46, b8);
    chk({24'h0, b8}, 32'h07);
    wr16(8'h45, 16'h0000);
    res(32'h0000000e, 16'h0002, 8'h03);
    wr_prod(32'h00000015);
    wr16(8'h45, 16'h0007);
    // done clear lands on the completing edge, the set wins
    repeat (32) @(negedge clk);
    host_u.wr(8'h49, 8'h01);
    res(32'h00000003, 16'h0000, 8'h41);
    // signed divide with compensation
    host_u.wr(8'h44, 8'hd0);
    wr_prod(32'hfffffff9);
    wr16(8'h45, 16'h0002);
    res(32'hfffffffc, 16'h0001, 8'h81);
    // kick: zero has no effect, one starts a multiply
    host_u.wr(8'h44, 8'h00);
    host_u.rd(8'h49, b8);
    chk({24'h0, b8}, 32'h80);
    host_u.wr(8'h44, 8'h08);
    res(32'h00000002, 16'h0001, 8'h01);
    // fraction divide, kick only
    host_u.wr(8'h44, 8'h60);
    wr16(8'h45, 16'h0004);
    wr16(8'h47, 16'h0001);
    host_u.rd(8'h49, b8);
    chk({24'h0, b8}, 32'h0);
    host_u.wr(8'h44, 8'h68);
    host_u.rd(8'h44, b8);
    chk({24'h0, b8}, 32'h60);
    res(32'h00024000, 16'h0000, 8'h41);
    // signed divide overflow: most negative over minus one
    host_u.wr(8'h44, 8'hc0);
    wr_prod(32'h80000000);
    wr16(8'h45, 16'hffff);
    res(32'h80000000, 16'h0000, 8'hc5);
    // signed accumulate with two's complement overflow
    host_u.wr(8'h44, 8'ha0);
    wr_prod(32'h7fffffff);
    wr16(8'h45, 16'h0001);
    wr16(8'h47, 16'h0001);
    res(32'h80000000, 16'h0001, 8'h85);
    // signed fraction divide by a negative divisor
    host_u.wr(8'h44, 8'he0);
    wr16(8'h45, 16'hfffe);
    wr16(8'h47, 16'h0001);
    host_u.wr(8'h44, 8'he8);
    res(32'h00008000, 16'h0000, 8'hc1);
    complete_run();
  end
endmodule
